// ==== core/main_clk_pkg.sv ====
/*
 Shared constants and types for the main clock source selection block:
 register offsets, field positions, reset values, timing counts and the
 switch state encoding. Assumes a 25 MHz system clock and an APB register bus.
*/
package main_clk_pkg;

   // Clock rate
   localparam int unsigned CLK_FREQ_MHZ = 25;

   // Register byte offsets
   localparam logic [7:0] OFS_MAIN_OSC   = 8'h00;   // main_osc_reg
   localparam logic [7:0] OFS_STATUS     = 8'h04;   // power_ctrl_status_reg
   localparam logic [7:0] OFS_IRQ_MASK   = 8'h08;   // power_ctrl_irq_mask_reg
   localparam logic [7:0] OFS_FREQ_METER = 8'h0C;   // main_clk_freq_meter_reg

   // main_osc_reg fields
   localparam int unsigned MO_XT_EN_BIT    = 0;
   localparam int unsigned MO_RC_EN_BIT    = 3;
   localparam int unsigned MO_RC_FREQ_LSB  = 4;
   localparam int unsigned MO_XT_START_LSB = 8;
   localparam int unsigned MO_SEL_BIT      = 24;

   // power_ctrl_status_reg and irq mask fields
   localparam int unsigned ST_XT_STABLE_BIT = 0;
   localparam int unsigned ST_SEL_STAT_BIT  = 16;

   // main_clk_freq_meter_reg fields
   localparam int unsigned FM_COUNT_W      = 16;
   localparam int unsigned FM_READY_BIT    = 16;
   localparam int unsigned FM_RESTART_BIT  = 20;
   localparam int unsigned FM_WINDOW_TICKS = 16;   // Slow clock periods per measure

   // Reset values
   localparam logic       RST_RC_EN    = 1'b1;
   localparam logic [2:0] RST_RC_FREQ  = 3'h0;
   localparam logic [7:0] RST_XT_START = 8'h00;

   // Crystal start-up: slow clock ticks per start-up field unit
   localparam int unsigned XT_START_SCALE = 8;
   localparam int unsigned XT_CNT_W       = 11;

   // Source switch timing
   localparam int unsigned SETTLE_NS      = 160;
   localparam int unsigned SETTLE_CYC     = (SETTLE_NS * CLK_FREQ_MHZ + 999) / 1000;
   localparam int unsigned ARRIVE_US      = 100;
   localparam int unsigned ARRIVE_CYC     = ARRIVE_US * CLK_FREQ_MHZ;
   localparam int unsigned SW_CNT_W       = 12;

   // Source encoding
   localparam logic SRC_RC = 1'b0;
   localparam logic SRC_XT = 1'b1;

   // Switch sequence states, Gray along steady -> gate off -> arm
   typedef enum logic [1:0] {
      SW_STEADY   = 2'b00,
      SW_GATE_OFF = 2'b01,
      SW_ARM      = 2'b11
   } sw_state_t;

   // APB request bundle
   typedef struct packed {
      logic        psel;
      logic        penable;
      logic        pwrite;
      logic [7:0]  paddr;
      logic [31:0] pwdata;
   } apb_req_t;

   // APB answer bundle
   typedef struct packed {
      logic        pready;
      logic        pslverr;
      logic [31:0] prdata;
   } apb_rsp_t;

endpackage

// ==== core/main_clk_freq_meter.sv ====
/*
 Frequency meter for the selected main clock: counts main clock tick pulses
 over a fixed window of slow clock ticks. Assumes both tick inputs are
 one-cycle pulses synchronous to sys_clk.
*/
`timescale 1ns/1ps
module main_clk_freq_meter
   import main_clk_pkg::*;
(
   input  wire logic                  sys_clk,    // System clock
   input  wire logic                  sys_rst,    // Async reset, active high
   input  wire logic                  slow_tick,  // Slow clock period pulse
   input  wire logic                  main_tick,  // Selected main clock pulse
   input  wire logic                  restart,    // Start a new measure
   output logic      [FM_COUNT_W-1:0] count,      // Last measured count
   output logic                       ready       // Count valid
);

   typedef struct packed {
      logic                  busy;
      logic [4:0]            win;
      logic [FM_COUNT_W-1:0] acc;
      logic [FM_COUNT_W-1:0] count;
      logic                  ready;
   } fm_state_t;

   fm_state_t s_q;
   fm_state_t s_d;

   ////////////////////////////////////////////////////////////////////////////
   // Window opens on the first slow tick so the measure is not cut short
   always_comb begin
      s_d = s_q;
      if (restart) begin
         s_d.busy  = 1'b1;
         s_d.ready = 1'b0;
         s_d.win   = 5'h00;
         s_d.acc   = '0;
      end else if (s_q.busy) begin
         if (main_tick && s_q.win != 5'h00 && s_q.acc != '1) begin
            s_d.acc = s_q.acc + 1'b1;
         end
         if (slow_tick) begin
            if (s_q.win == 5'(FM_WINDOW_TICKS)) begin
               s_d.busy  = 1'b0;
               s_d.ready = 1'b1;
               s_d.count = s_d.acc;
            end else begin
               s_d.win = s_q.win + 5'h01;
            end
         end
      end
   end

   always_ff @(posedge sys_clk or posedge sys_rst) begin
      if (sys_rst) begin
         s_q <= '0;
      end else begin
         s_q <= s_d;
      end
   end

   assign count = s_q.count;
   assign ready = s_q.ready;

endmodule

// ==== core/main_clk_select.sv ====
/*
 Main clock source selection: APB register file, crystal start-up timing,
 break-before-make source switch with completion status and interrupt, and
 the main clock frequency meter hookup. Oscillator activity arrives as
 one-cycle tick pulses synchronous to sys_clk; the gate outputs steer the
 actual clock mux elsewhere.
*/
`timescale 1ns/1ps

module main_clk_select
   import main_clk_pkg::*;
(
   input  wire logic        sys_clk,          // System clock, 25 MHz
   input  wire logic        sys_rst,          // Async reset, active high
   input  wire logic        psel,             // APB select
   input  wire logic        penable,          // APB enable
   input  wire logic        pwrite,           // APB direction
   input  wire logic [7:0]  paddr,            // APB byte address
   input  wire logic [31:0] pwdata,           // APB write data
   output logic             pready,           // APB ready
   output logic             pslverr,          // APB error, unmapped address
   output logic [31:0]      prdata,           // APB read data
   input  wire logic        slow_tick,        // Slow clock period pulse
   input  wire logic        rc_tick,          // Fast RC activity pulse
   input  wire logic        xtal_tick,        // Crystal activity pulse
   input  wire logic        wait_mode,        // System in wait mode
   output logic             fast_rc_enable,   // Fast RC oscillator enable
   output logic [2:0]       fast_rc_freq_sel, // Fast RC frequency choice
   output logic             crystal_osc_enable, // Crystal oscillator enable
   output logic             rc_gate,          // Main clock mux: RC leg on
   output logic             xtal_gate,        // Main clock mux: crystal leg on
   output logic             main_osc_select_status, // Switch done flag
   output logic             irq               // Interrupt to processor
);

   ////////////////////////////////////////////////////////////////////////////
   // State

   typedef struct packed {
      logic                xt_en;
      logic                rc_en;
      logic [2:0]          rc_freq;
      logic [7:0]          xt_start;
      logic                osc_sel;
      logic [XT_CNT_W-1:0] xt_cnt;
      logic                xt_stable;
      sw_state_t           sw;
      logic                cur_src;
      logic                fail;
      logic [SW_CNT_W-1:0] sw_cnt;
      logic                sel_status;
      logic                irq_mask;
      logic                irq;
      logic                rc_gate;
      logic                xt_gate;
      logic                fm_restart;
      apb_rsp_t            rsp;
   } core_state_t;

   core_state_t s_q;
   core_state_t s_d;
   apb_req_t    req;

   logic [FM_COUNT_W-1:0] fm_count;
   logic                  fm_ready;
   logic                  main_tick;

   ////////////////////////////////////////////////////////////////////////////
   // Helpers

   // Register decode shared by read and write paths
   function automatic logic [2:0] reg_hit(input logic [7:0] addr);
      case (addr)
         OFS_MAIN_OSC:   reg_hit = 3'h1;
         OFS_STATUS:     reg_hit = 3'h2;
         OFS_IRQ_MASK:   reg_hit = 3'h3;
         OFS_FREQ_METER: reg_hit = 3'h4;
         default:        reg_hit = 3'h0;
      endcase
   endfunction

   // Crystal start-up length in slow ticks
   function automatic logic [XT_CNT_W-1:0] xt_limit(input logic [7:0] st);
      xt_limit = XT_CNT_W'({3'h0, st} * XT_CNT_W'(XT_START_SCALE));
   endfunction

   assign req = '{psel: psel, penable: penable, pwrite: pwrite,
                  paddr: paddr, pwdata: pwdata};

   // Meter sees only what passes the active gate, never a raw oscillator
   assign main_tick = (s_q.rc_gate & rc_tick) | (s_q.xt_gate & xtal_tick);

   ////////////////////////////////////////////////////////////////////////////
   // Next state

   always_comb begin
      logic       wr_now;
      logic       rd_setup;
      logic [2:0] hit;
      logic       target_tick;
      wr_now      = 1'b0;
      rd_setup    = 1'b0;
      hit         = 3'h0;
      target_tick = 1'b0;
      s_d         = s_q;
      s_d.fm_restart = 1'b0;

      // APB: answer one cycle after setup; write lands on the ready edge
      hit      = reg_hit(req.paddr);
      rd_setup = req.psel & ~req.penable;
      wr_now   = req.psel & req.penable & s_q.rsp.pready & req.pwrite;
      s_d.rsp.pready  = rd_setup;
      s_d.rsp.pslverr = rd_setup & (hit == 3'h0);
      if (rd_setup) begin
         s_d.rsp.prdata = 32'h0000_0000;
         case (hit)
            3'h1: begin
               s_d.rsp.prdata[MO_XT_EN_BIT]                    = s_q.xt_en;
               s_d.rsp.prdata[MO_RC_EN_BIT]                    = s_q.rc_en;
               s_d.rsp.prdata[MO_RC_FREQ_LSB +: 3]             = s_q.rc_freq;
               s_d.rsp.prdata[MO_XT_START_LSB +: 8]            = s_q.xt_start;
               s_d.rsp.prdata[MO_SEL_BIT]                      = s_q.osc_sel;
            end
            3'h2: begin
               s_d.rsp.prdata[ST_XT_STABLE_BIT] = s_q.xt_stable;
               s_d.rsp.prdata[ST_SEL_STAT_BIT]  = s_q.sel_status;
            end
            3'h3: s_d.rsp.prdata[ST_SEL_STAT_BIT] = s_q.irq_mask;
            3'h4: begin
               s_d.rsp.prdata[FM_COUNT_W-1:0] = fm_count;
               s_d.rsp.prdata[FM_READY_BIT]   = fm_ready;
            end
            default: s_d.rsp.prdata = 32'h0000_0000;
         endcase
      end
      if (!req.psel) begin
         s_d.rsp.pslverr = 1'b0;
      end

      // Register writes
      if (wr_now) begin
         case (hit)
            3'h1: begin
               s_d.xt_en    = req.pwdata[MO_XT_EN_BIT];
               s_d.rc_en    = req.pwdata[MO_RC_EN_BIT];
               s_d.xt_start = req.pwdata[MO_XT_START_LSB +: 8];
               s_d.osc_sel  = req.pwdata[MO_SEL_BIT];
               s_d.fail     = 1'b0;
               // A frequency change that rides along with enabling is dropped
               if (s_q.rc_en || !req.pwdata[MO_RC_EN_BIT]) begin
                  s_d.rc_freq = req.pwdata[MO_RC_FREQ_LSB +: 3];
               end
            end
            3'h3: s_d.irq_mask = req.pwdata[ST_SEL_STAT_BIT];
            3'h4: s_d.fm_restart = req.pwdata[FM_RESTART_BIT];
            default: s_d.fail = s_q.fail;
         endcase
      end

      // Wait mode pulls the choice back to the fast RC
      if (wait_mode) begin
         s_d.osc_sel = SRC_RC;
         s_d.rc_en   = 1'b1;
      end

      // Crystal start-up counted in slow ticks; disable clears at once
      if (!s_d.xt_en) begin
         s_d.xt_cnt    = '0;
         s_d.xt_stable = 1'b0;
      end else if (!s_q.xt_stable && slow_tick) begin
         if (s_q.xt_cnt >= xt_limit(s_q.xt_start)) begin
            s_d.xt_stable = 1'b1;
         end else begin
            s_d.xt_cnt = s_q.xt_cnt + 1'b1;
         end
      end

      // Break-before-make switch: both legs off, settle, then wait for
      // the new source to show activity before opening its leg
      target_tick = s_q.osc_sel ? (xtal_tick & s_q.xt_en) : (rc_tick & s_q.rc_en);
      case (s_q.sw)
         SW_STEADY: begin
            if (s_q.osc_sel != s_q.cur_src && !s_q.fail) begin
               s_d.sw         = SW_GATE_OFF;
               s_d.rc_gate    = 1'b0;
               s_d.xt_gate    = 1'b0;
               s_d.sel_status = 1'b0;
               s_d.sw_cnt     = '0;
            end
         end
         SW_GATE_OFF: begin
            if (s_q.sw_cnt == SW_CNT_W'(SETTLE_CYC - 1)) begin
               s_d.sw     = SW_ARM;
               s_d.sw_cnt = '0;
            end else begin
               s_d.sw_cnt = s_q.sw_cnt + 1'b1;
            end
         end
         SW_ARM: begin
            if (target_tick) begin
               // New source is alive: open its leg and report done
               s_d.sw         = SW_STEADY;
               s_d.cur_src    = s_q.osc_sel;
               s_d.rc_gate    = (s_q.osc_sel == SRC_RC);
               s_d.xt_gate    = (s_q.osc_sel == SRC_XT);
               s_d.sel_status = 1'b1;
            end else if (s_q.sw_cnt == SW_CNT_W'(ARRIVE_CYC - 1)) begin
               // No clock arrived: fall back to RC, status low unless RC was the target
               s_d.sw         = SW_STEADY;
               s_d.cur_src    = SRC_RC;
               s_d.rc_gate    = 1'b1;
               s_d.xt_gate    = 1'b0;
               s_d.fail       = (s_q.osc_sel == SRC_XT);
               s_d.sel_status = (s_q.osc_sel == SRC_RC);
               s_d.rc_en      = 1'b1;
            end else begin
               s_d.sw_cnt = s_q.sw_cnt + 1'b1;
            end
         end
         default: begin
            s_d.sw      = SW_STEADY;
            s_d.cur_src = SRC_RC;
            s_d.rc_gate = 1'b1;
            s_d.xt_gate = 1'b0;
         end
      endcase

      // Crystal disabled while its leg is open drops the status
      if (s_q.xt_gate && !s_d.xt_en) begin
         s_d.sel_status = 1'b0;
      end

      // Interrupt follows the completion flag through the mask
      s_d.irq = s_d.sel_status & s_d.irq_mask;
   end

   ////////////////////////////////////////////////////////////////////////////
   // State register; reset lands on the fast RC with the switch complete

   always_ff @(posedge sys_clk or posedge sys_rst) begin
      if (sys_rst) begin
         s_q            <= '0;
         s_q.rc_en      <= RST_RC_EN;
         s_q.rc_freq    <= RST_RC_FREQ;
         s_q.xt_start   <= RST_XT_START;
         s_q.osc_sel    <= SRC_RC;
         s_q.cur_src    <= SRC_RC;
         s_q.sw         <= SW_STEADY;
         s_q.rc_gate    <= 1'b1;
         s_q.sel_status <= 1'b1;
      end else begin
         s_q <= s_d;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Frequency meter on the gated main clock

   main_clk_freq_meter u_meter (
      .sys_clk   (sys_clk),
      .sys_rst   (sys_rst),
      .slow_tick (slow_tick),
      .main_tick (main_tick),
      .restart   (s_q.fm_restart),
      .count     (fm_count),
      .ready     (fm_ready)
   );

   ////////////////////////////////////////////////////////////////////////////
   // Outputs, all from flops

   assign pready                 = s_q.rsp.pready;
   assign pslverr                = s_q.rsp.pslverr;
   assign prdata                 = s_q.rsp.prdata;
   assign fast_rc_enable         = s_q.rc_en;
   assign fast_rc_freq_sel       = s_q.rc_freq;
   assign crystal_osc_enable     = s_q.xt_en;
   assign rc_gate                = s_q.rc_gate;
   assign xtal_gate              = s_q.xt_gate;
   assign main_osc_select_status = s_q.sel_status;
   assign irq                    = s_q.irq;

endmodule

// ==== verification/main_clk_select_checker.sv ====
/*
 Port checker for the main clock source selection block.
 Assumes it is bound to main_clk_select and runs in the sys_clk domain.
*/
`timescale 1ns/1ps
module main_clk_select_checker (
   input wire logic        sys_clk,                // Clock
   input wire logic        sys_rst,                // Reset
   input wire logic        psel,                   // APB select
   input wire logic        penable,                // APB enable
   input wire logic        pwrite,                 // APB direction
   input wire logic [7:0]  paddr,                  // APB address
   input wire logic [31:0] pwdata,                 // APB write data
   input wire logic        pready,                 // APB ready
   input wire logic        pslverr,                // APB error
   input wire logic [31:0] prdata,                 // APB read data
   input wire logic        slow_tick,              // Slow tick
   input wire logic        rc_tick,                // RC tick
   input wire logic        xtal_tick,              // Crystal tick
   input wire logic        wait_mode,              // Wait mode
   input wire logic        fast_rc_enable,         // RC enable
   input wire logic [2:0]  fast_rc_freq_sel,       // RC frequency
   input wire logic        crystal_osc_enable,     // Crystal enable
   input wire logic        rc_gate,                // RC leg
   input wire logic        xtal_gate,              // Crystal leg
   input wire logic        main_osc_select_status, // Switch done
   input wire logic        irq                     // Interrupt
);
   default clocking cb @(posedge sys_clk); endclocking
   default disable iff (sys_rst);

   ////////////////////////////////////////////////////////////////////////////
   // Break-before-make: an overlap would glitch the main clock
   gates_excl_a: assert property (!(rc_gate && xtal_gate))
      else $error("both clock legs open");
   break_gap_a: assert property ($fell(rc_gate) |-> (!rc_gate && !xtal_gate)[*4])
      else $error("settle gap too short");
   xt_open_a: assert property ($rose(xtal_gate) |-> $past(xtal_tick) && crystal_osc_enable)
      else $error("crystal leg opened without crystal activity");
   xt_done_a: assert property ($rose(xtal_gate) |-> main_osc_select_status)
      else $error("status missing when crystal leg opens");
   stat_switch_a: assert property (!rc_gate && !xtal_gate |-> !main_osc_select_status)
      else $error("status high during switch");

   ////////////////////////////////////////////////////////////////////////////
   // Interrupt follows status through the mask in the same cycle, never ahead of it
   irq_cause_a: assert property (irq |-> main_osc_select_status)
      else $error("interrupt without status");
   irq_drop_a: assert property ($fell(main_osc_select_status) |=> !irq)
      else $error("interrupt outlived status");
   wait_rc_a: assert property (wait_mode |-> ##[1:2] fast_rc_enable)
      else $error("wait mode left RC disabled");
   apb_ans_a: assert property (psel && !penable |=> pready)
      else $error("register access not answered");

   // Main scenarios reached
   cover property ($rose(xtal_gate));
   cover property ($rose(irq));
   cover property (pready && pslverr);
   cover property (wait_mode && xtal_gate);
endmodule

// ==== verification/tb_top.sv ====
/*
 Self-checking bench for main_clk_select: APB master tasks, oscillator tick
 stimulus and one task per scenario. Assumes the package register map.
*/
`timescale 1ns/1ps
module tb_top;
   import main_clk_pkg::*;
   logic        sys_clk, sys_rst, psel, penable, pwrite, pready, pslverr;
   logic        slow_tick, rc_tick, xtal_tick, wait_mode, xtal_present;
   logic        fast_rc_enable, crystal_osc_enable, rc_gate, xtal_gate, stat, irq;
   logic [2:0]  fast_rc_freq_sel;
   logic [3:0]  tick_cnt;
   logic [7:0]  paddr;
   logic [31:0] pwdata, prdata;
   int          err_count, n_compared, cyc;

   main_clk_select dut_u (.sys_clk(sys_clk), .sys_rst(sys_rst), .psel(psel),
      .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pready(pready),
      .pslverr(pslverr), .prdata(prdata), .slow_tick(slow_tick), .rc_tick(rc_tick),
      .xtal_tick(xtal_tick), .wait_mode(wait_mode), .fast_rc_enable(fast_rc_enable),
      .fast_rc_freq_sel(fast_rc_freq_sel), .crystal_osc_enable(crystal_osc_enable),
      .rc_gate(rc_gate), .xtal_gate(xtal_gate), .main_osc_select_status(stat), .irq(irq));

   ////////////////////////////////////////////////////////////////////////////
   // Clock, oscillator ticks and hang guard; a stopped crystal gives no ticks
   initial begin
      sys_clk = 1'b0;
      forever #20 sys_clk = ~sys_clk;
   end
   always @(posedge sys_clk) begin
      tick_cnt  <= tick_cnt + 4'h1;
      slow_tick <= (tick_cnt[1:0] == 2'h3);
      rc_tick   <= (tick_cnt[1:0] == 2'h1);
      xtal_tick <= xtal_present && crystal_osc_enable && tick_cnt[0];
      cyc <= cyc + 1;
      if (cyc == 40000) begin
         err_count++;
         print_verdict();
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Compare, APB transfer and polling helpers
   task automatic chk(input logic [31:0] exp, input logic [31:0] got);
      n_compared++;
      if (got !== exp) begin
         err_count++;
         $display("CHECK FAILED t=%0t exp=%h got=%h", $time, exp, got);
      end
   endtask
   function automatic logic [31:0] outs();
      return {26'h0, rc_gate, xtal_gate, stat, fast_rc_enable, crystal_osc_enable, irq};
   endfunction
   task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d,
                      output logic [31:0] q, output logic e);
      int n;
      @(posedge sys_clk);
      psel <= 1'b1; penable <= 1'b0; pwrite <= w; paddr <= a; pwdata <= d;
      @(posedge sys_clk);
      penable <= 1'b1;
      n = 0;
      do begin
         @(posedge sys_clk);
         n++;
      end while (pready !== 1'b1 && n < 16);
      chk(32'h1, {31'h0, pready});
      q = prdata;
      e = pslverr;
      psel <= 1'b0; penable <= 1'b0;
   endtask
   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      logic [31:0] q; logic e;
      apb(1'b1, a, d, q, e);
   endtask
   task automatic rd(input logic [7:0] a, output logic [31:0] q);
      logic e;
      apb(1'b0, a, 32'h0, q, e);
   endtask
   task automatic poll(input logic [7:0] a, input logic [31:0] m, input logic [31:0] v);
      logic [31:0] q;
      int n;
      n = 0;
      do begin
         rd(a, q);
         n++;
      end while ((q & m) !== v && n < 200);
      chk(v, q & m);
   endtask

   ////////////////////////////////////////////////////////////////////////////
   // Scenarios
   task automatic s_reset();
      logic [31:0] q; logic e;
      rd(OFS_MAIN_OSC, q); chk(32'h0000_0008, q);
      chk(32'h2C, outs());
      rd(OFS_STATUS, q); chk(32'h0001_0000, q);
      apb(1'b0, 8'h10, 32'h0, q, e); chk(32'h1, {31'h0, e});
      chk(32'h0, q);
   endtask
   task automatic s_xtal_good();
      logic [31:0] q;
      // Master clock is taken to sit on the slow clock already
      xtal_present <= 1'b1;
      wr(OFS_MAIN_OSC, 32'h0000_0109);
      poll(OFS_STATUS, 32'h1, 32'h1);
      wr(OFS_MAIN_OSC, 32'h0100_0109);
      poll(OFS_MAIN_OSC, 32'h0100_0000, 32'h0100_0000);
      poll(OFS_STATUS, 32'h0001_0000, 32'h0001_0000);
      chk(32'h1E, outs());
      wr(OFS_IRQ_MASK, 32'h0001_0000); repeat (2) @(posedge sys_clk);
      chk(32'h1F, outs());
      wr(OFS_IRQ_MASK, 32'h0); repeat (2) @(posedge sys_clk);
      chk(32'h1E, outs());
      // Two crystal ticks per slow period: RC ticks would give half the count
      wr(OFS_FREQ_METER, 32'h0010_0000);
      poll(OFS_FREQ_METER, 32'h0001_0000, 32'h0001_0000);
      rd(OFS_FREQ_METER, q); chk(32'h1, {31'h0, q[15:0] >= 16'h1F && q[15:0] <= 16'h21});
      // Outputs change on the edge the write lands, after the task returns, so look one edge later
      wr(OFS_MAIN_OSC, 32'h0100_0101); @(posedge sys_clk);
      chk(32'h0, {31'h0, fast_rc_enable});
      wr(OFS_MAIN_OSC, 32'h0100_0129); @(posedge sys_clk);
      chk(32'h0, {29'h0, fast_rc_freq_sel});
      wr(OFS_MAIN_OSC, 32'h0100_0129); @(posedge sys_clk);
      chk(32'h2, {29'h0, fast_rc_freq_sel});
      wr(OFS_MAIN_OSC, 32'h0000_0129);
      poll(OFS_STATUS, 32'h0001_0000, 32'h0001_0000);
      chk(32'h2E, outs());
      wr(OFS_MAIN_OSC, 32'h0000_0028); repeat (2) @(posedge sys_clk);
      chk(32'h2C, outs());
   endtask
   task automatic s_wait();
      wr(OFS_MAIN_OSC, 32'h0000_0109);
      poll(OFS_STATUS, 32'h1, 32'h1);
      wr(OFS_MAIN_OSC, 32'h0100_0109);
      poll(OFS_STATUS, 32'h0001_0000, 32'h0001_0000);
      // Mask set first so the interrupt must rise with the completion flag
      wr(OFS_IRQ_MASK, 32'h0001_0000);
      wait_mode <= 1'b1;
      repeat (3) @(posedge sys_clk);
      poll(OFS_STATUS, 32'h0001_0000, 32'h0001_0000);
      chk(32'h2F, outs());
      wr(OFS_IRQ_MASK, 32'h0);
      wait_mode <= 1'b0;
      wr(OFS_MAIN_OSC, 32'h0000_0008);
      xtal_present <= 1'b0;
   endtask
   task automatic s_xtal_absent();
      logic [31:0] q;
      wr(OFS_MAIN_OSC, 32'h0000_0109);
      poll(OFS_STATUS, 32'h1, 32'h1);
      wr(OFS_MAIN_OSC, 32'h0100_0109);
      // Reads span the whole arrival timeout; the flag never rises
      repeat (880) begin
         rd(OFS_STATUS, q); chk(32'h0, {31'h0, q[16]});
      end
      chk(32'h26, outs());
      wr(OFS_MAIN_OSC, 32'h0000_0008); repeat (2) @(posedge sys_clk);
      chk(32'h0, {31'h0, crystal_osc_enable});
   endtask

   ////////////////////////////////////////////////////////////////////////////
   // Verdict and main sequence
   task automatic print_verdict();
      $display("Comparisons %0d, mismatches %0d", n_compared, err_count);
      if (err_count == 0 && n_compared > 0) $display("TEST PASSED");
      else $display("TEST FAILED");
      $finish;
   endtask
   initial begin
      sys_rst = 1'b1; psel = 1'b0; penable = 1'b0; pwrite = 1'b0; paddr = 8'h00;
      pwdata = 32'h0; slow_tick = 1'b0; rc_tick = 1'b0; xtal_tick = 1'b0;
      wait_mode = 1'b0; xtal_present = 1'b0; tick_cnt = 4'h0;
      cyc = 0; err_count = 0; n_compared = 0;
      repeat (12) @(posedge sys_clk);
      sys_rst <= 1'b0;
      s_reset();
      s_xtal_good();
      s_wait();
      s_xtal_absent();
      print_verdict();
   end
endmodule

bind main_clk_select main_clk_select_checker chk_u (.sys_clk(sys_clk), .sys_rst(sys_rst),
   .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
   .pready(pready), .pslverr(pslverr), .prdata(prdata), .slow_tick(slow_tick),
   .rc_tick(rc_tick), .xtal_tick(xtal_tick), .wait_mode(wait_mode),
   .fast_rc_enable(fast_rc_enable), .fast_rc_freq_sel(fast_rc_freq_sel),
   .crystal_osc_enable(crystal_osc_enable), .rc_gate(rc_gate), .xtal_gate(xtal_gate),
   .main_osc_select_status(main_osc_select_status), .irq(irq));
